// File: rtl/tpp_top.sv
// transmit preamble passthrough and pause frame generator with ahb-lite registers
//
// Functional notes
// [RQ1] With passthrough on, the first eight client bytes go out as the preamble.
// [RQ2] Passthrough is bit 0 of its control register, reset 0, when the block makes its own.
// [RQ3] Request bit 0 sends an xon pause frame with quanta zero.
// [RQ4] Request bit 1 sends an xoff pause frame with the programmed quanta.
// [RQ5] Both request bits set together send no pause frame at all.
// [RQ6] The quanta register keeps 16 low bits that every xoff frame carries.
// [RQ7] Enable bit 0, reset 1, gates all pause generation.
// [RQ8] Request register bits above the two request bits have no effect.
// [RQ9] Pause frames carry da, sa, mac control type, opcode, quanta, pad and crc.
`timescale 1ns/1ps
`default_nettype none
`include "tpp_consts.svh"
module tpp_top (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             hsel,
  input  wire logic [15:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic      [31:0]      hrdata,
  input  wire logic             cl_valid,
  input  wire tpp_pkg::tpp_beat_s cl_beat,
  output logic                  cl_ready,
  output tpp_pkg::tpp_tx_s      tx_out
);
  import tpp_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // state
  tpp_state_e  state, next_state;
  logic [5:0]  cnt, next_cnt;
  logic [31:0] crc, next_crc;
  logic        kind_pause, next_kind_pause;
  logic        pass_frame, next_pass_frame;
  logic        xoff_frame, next_xoff_frame;
  logic [15:0] q_lat, next_q_lat;
  tpp_tx_s     next_tx;
  logic        next_cl_ready;
  logic [1:0]  req_clr;
  logic        pause_go;
  logic        take;
  logic [7:0]  pg_byte;
  logic [31:0] crc_step;

  // registers and bus
  logic        pass_ctl, next_pass_ctl;
  logic [1:0]  req, next_req;
  logic [15:0] quanta, next_quanta;
  logic        en, next_en;
  logic [47:0] src, next_src;
  logic [31:0] pcnt, next_pcnt;
  logic        wr_pend, next_wr_pend;
  logic [13:0] wr_idx, next_wr_idx;
  logic [31:0] next_hrdata;
  logic        acc;

  ////////////////////////////////////////////////////////////////////////
  // frame byte source and crc step
  tpp_pause_gen u_gen (
    .idx      (cnt),
    .src_addr (src),
    .quanta   (q_lat),
    .crc      (crc),
    .data     (pg_byte)
  );

  tpp_crc32 u_crc (
    .crc_in  (crc),
    .data    (pg_byte),
    .crc_out (crc_step)
  );

  ////////////////////////////////////////////////////////////////////////
  // transmit sequencer
  assign pause_go = en && (req == `TPP_REQ_XON || req == `TPP_REQ_XOFF); // [RQ5] [RQ7]
  assign take     = cl_valid && cl_ready;

  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_crc        = crc;
    next_kind_pause = kind_pause;
    next_pass_frame = pass_frame;
    next_xoff_frame = xoff_frame;
    next_q_lat      = q_lat;
    next_tx         = '0;
    req_clr         = 2'b00;
    next_pcnt       = pcnt;
    unique case (state)
      TPP_IDLE: begin
        next_cnt = 6'd0;
        if (pause_go) begin
          // pause frames go first between frames
          next_state      = TPP_PRE;
          next_kind_pause = 1'b1;
          next_xoff_frame = req[1];
          next_q_lat      = req[1] ? quanta : 16'h0000; // [RQ3] [RQ4] [RQ6]
          req_clr         = req;
          next_pcnt       = pcnt + 32'h1;
        end else if (cl_valid) begin
          next_kind_pause = 1'b0;
          next_pass_frame = pass_ctl;
          next_state      = pass_ctl ? TPP_CLIENT : TPP_PRE; // [RQ1] [RQ2]
        end
      end
      TPP_PRE: begin
        // own preamble and start delimiter
        next_tx.valid = 1'b1;
        next_tx.pre   = 1'b1;
        next_tx.data  = (cnt == `TPP_PRE_LAST) ? `TPP_SFD_BYTE : `TPP_PRE_BYTE; // [RQ2]
        next_cnt      = cnt + 6'd1;
        if (cnt == `TPP_PRE_LAST) begin
          next_cnt   = 6'd0;
          next_crc   = `TPP_CRC_INIT;
          next_state = kind_pause ? TPP_PAUSE : TPP_CLIENT;
        end
      end
      TPP_CLIENT: begin
        if (take) begin
          next_tx.valid = 1'b1;
          next_tx.data  = cl_beat.data;
          next_tx.last  = cl_beat.last;
          next_tx.pre   = pass_frame && (cnt < `TPP_PRE_LEN); // [RQ1]
          next_cnt      = (cnt < `TPP_PRE_LEN) ? cnt + 6'd1 : cnt;
          if (cl_beat.last) begin
            next_cnt   = 6'd0;
            next_state = TPP_IFG;
          end
        end
      end
      TPP_PAUSE: begin
        // mac control frame, crc over the first 60 bytes
        next_tx.valid = 1'b1;
        next_tx.data  = pg_byte; // [RQ9]
        next_cnt      = cnt + 6'd1;
        if (cnt < `TPP_FCS_START) next_crc = crc_step;
        if (cnt == `TPP_PAUSE_LAST) begin
          next_tx.last = 1'b1;
          next_cnt     = 6'd0;
          next_state   = TPP_IFG;
        end
      end
      TPP_IFG: begin
        next_cnt = cnt + 6'd1;
        if (cnt == `TPP_IFG_LAST) next_state = TPP_IDLE;
      end
    endcase
    next_cl_ready = (next_state == TPP_CLIENT);
  end

  // sequencer registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state      <= TPP_IDLE;
      cnt        <= 6'd0;
      crc        <= `TPP_CRC_INIT;
      kind_pause <= 1'b0;
      pass_frame <= 1'b0;
      xoff_frame <= 1'b0;
      q_lat      <= 16'h0000;
      tx_out     <= '0;
      cl_ready   <= 1'b0;
      pcnt       <= 32'h0;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      crc        <= next_crc;
      kind_pause <= next_kind_pause;
      pass_frame <= next_pass_frame;
      xoff_frame <= next_xoff_frame;
      q_lat      <= next_q_lat;
      tx_out     <= next_tx;
      cl_ready   <= next_cl_ready;
      pcnt       <= next_pcnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite register slave, zero wait states
  assign acc = hsel && htrans[1] && hready && (hsize == 3'b010);

  always_comb begin
    next_wr_pend  = acc && hwrite;
    next_wr_idx   = haddr[15:2];
    next_pass_ctl = pass_ctl;
    next_req      = req & ~req_clr;
    next_quanta   = quanta;
    next_en       = en;
    next_src      = src;
    if (wr_pend) begin
      // a software write wins over the hardware clear
      unique case (wr_idx)
        `TPP_IDX_PRE_CTL:   next_pass_ctl = hwdata[`TPP_BIT_PASS]; // [RQ2]
        `TPP_IDX_PAUSE_REQ: next_req      = hwdata[1:0]; // [RQ8]
        `TPP_IDX_QUANTA:    next_quanta   = hwdata[15:0]; // [RQ6]
        `TPP_IDX_PAUSE_EN:  next_en       = hwdata[`TPP_BIT_EN]; // [RQ7]
        `TPP_IDX_SRC_LO:    next_src[31:0]  = hwdata;
        `TPP_IDX_SRC_HI:    next_src[47:32] = hwdata[15:0];
        default: ;
      endcase
    end
    // read data from next values, so a write just before is seen
    next_hrdata = hrdata;
    if (acc && !hwrite) begin
      unique case (haddr[15:2])
        `TPP_IDX_PRE_CTL:   next_hrdata = {31'h0, next_pass_ctl};
        `TPP_IDX_PAUSE_REQ: next_hrdata = {30'h0, next_req};
        `TPP_IDX_QUANTA:    next_hrdata = {16'h0, next_quanta};
        `TPP_IDX_PAUSE_EN:  next_hrdata = {31'h0, next_en};
        `TPP_IDX_SRC_LO:    next_hrdata = next_src[31:0];
        `TPP_IDX_SRC_HI:    next_hrdata = {16'h0, next_src[47:32]};
        `TPP_IDX_STATUS:    next_hrdata = {29'h0, pass_frame, kind_pause,
                                           state != TPP_IDLE};
        `TPP_IDX_PAUSE_CNT: next_hrdata = next_pcnt;
        default:            next_hrdata = 32'h0;
      endcase
    end
  end

  // register file
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_pend   <= 1'b0;
      wr_idx    <= 14'h0;
      pass_ctl  <= `TPP_RST_PRE_CTL; // [RQ2]
      req       <= `TPP_RST_PAUSE_REQ;
      quanta    <= `TPP_RST_QUANTA;
      en        <= `TPP_RST_PAUSE_EN; // [RQ7]
      src       <= `TPP_RST_SRC;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend   <= next_wr_pend;
      wr_idx    <= next_wr_idx;
      pass_ctl  <= next_pass_ctl;
      req       <= next_req;
      quanta    <= next_quanta;
      en        <= next_en;
      src       <= next_src;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_pass_no_gen: assert property ( // [RQ1]
    (state == TPP_IDLE && !pause_go && cl_valid && pass_ctl) |=> state == TPP_CLIENT)
    else $error("passthrough frame got own preamble");
  a_pass_flag: assert property ( // [RQ1]
    (state == TPP_CLIENT && take && pass_frame && cnt < `TPP_PRE_LEN) |=> tx_out.pre)
    else $error("client preamble byte not marked");
  a_own_pre_sfd: assert property ( // [RQ2]
    (state == TPP_IDLE && next_state == TPP_PRE) |=> ##1 tx_out.data == `TPP_PRE_BYTE
      ##7 (tx_out.data == `TPP_SFD_BYTE && tx_out.pre))
    else $error("own preamble wrong");
  a_xon_zero: assert property ( // [RQ3]
    (state == TPP_PAUSE && !xoff_frame && (cnt == 6'd16 || cnt == 6'd17))
      |=> tx_out.data == 8'h00)
    else $error("xon quanta not zero");
  a_xoff_latch: assert property ( // [RQ4]
    (state == TPP_IDLE && pause_go && req == `TPP_REQ_XOFF) |=> q_lat == $past(quanta))
    else $error("xoff quanta not taken");
  a_xoff_bytes: assert property ( // [RQ6]
    (state == TPP_PAUSE && xoff_frame && cnt == 6'd16)
      |=> tx_out.data == q_lat[15:8] ##1 tx_out.data == q_lat[7:0])
    else $error("xoff quanta bytes wrong");
  a_both_none: assert property ( // [RQ5]
    (state == TPP_IDLE && req == 2'b11) |=> !kind_pause || state == TPP_IDLE)
    else $error("pause sent with both requests");
  a_en_gate: assert property ( // [RQ7]
    (state == TPP_IDLE && !en) |=> state != TPP_PRE || !kind_pause)
    else $error("pause sent while disabled");
  a_req_rsvd: assert property ( // [RQ8]
    (wr_pend && wr_idx == `TPP_IDX_PAUSE_REQ) |=> req == $past(hwdata[1:0]))
    else $error("request write wrong");
  a_ctl_frame: assert property ( // [RQ9]
    (state == TPP_PAUSE && cnt == 6'd12) |=> tx_out.data == 8'h88 ##1 tx_out.data == 8'h08
      ##50 (tx_out.last && tx_out.valid))
    else $error("pause frame layout wrong");
  // both requests set are kept, only software may change them
  a_both_stay: assert property ( // [RQ5]
    (state == TPP_IDLE && req == 2'b11) |=> req == 2'b11 || $past(wr_pend))
    else $error("both requests cleared by hardware");

  c_xon: cover property (state == TPP_PAUSE && cnt == 6'd0 && !xoff_frame);
  c_xoff: cover property (state == TPP_PAUSE && cnt == 6'd0 && xoff_frame);
  c_pass: cover property (state == TPP_CLIENT && take && pass_frame && cnt == 6'd7);
  c_both: cover property (state == TPP_IDLE && req == 2'b11);
endmodule
`default_nettype wire

// File: inc/tpp_consts.svh
// constants of the transmit preamble and pause control block
`ifndef TPP_CONSTS_SVH
`define TPP_CONSTS_SVH
// register word indices, byte address is four times the index
`define TPP_IDX_PRE_CTL   14'h1100
`define TPP_IDX_PAUSE_REQ 14'h1140
`define TPP_IDX_QUANTA    14'h1141
`define TPP_IDX_PAUSE_EN  14'h1142
`define TPP_IDX_SRC_LO    14'h1144
`define TPP_IDX_SRC_HI    14'h1145
`define TPP_IDX_STATUS    14'h1146
`define TPP_IDX_PAUSE_CNT 14'h1147
// reset values
`define TPP_RST_PRE_CTL   1'b0
`define TPP_RST_PAUSE_REQ 2'b00
`define TPP_RST_QUANTA    16'h0000
`define TPP_RST_PAUSE_EN  1'b1
`define TPP_RST_SRC       48'h000000000000
// field positions
`define TPP_BIT_PASS      0
`define TPP_BIT_EN        0
`define TPP_REQ_XON       2'b01
`define TPP_REQ_XOFF      2'b10
// frame layout
`define TPP_PRE_BYTE      8'h55
`define TPP_SFD_BYTE      8'hd5
`define TPP_PRE_LAST      6'd7
`define TPP_PRE_LEN       6'd8
`define TPP_PAUSE_DA      48'h0180c2000001
`define TPP_CTL_TYPE      16'h8808
`define TPP_PAUSE_OPCODE  16'h0001
`define TPP_FCS_START     6'd60
`define TPP_PAUSE_LAST    6'd63
`define TPP_IFG_LAST      6'd11
`define TPP_CRC_INIT      32'hffffffff
`define TPP_CRC_POLY      32'hedb88320
`endif

// File: inc/tpp_pkg.sv
// types of the transmit preamble and pause control block
`default_nettype none
package tpp_pkg;
  typedef enum logic [2:0] {
    TPP_IDLE, TPP_PRE, TPP_CLIENT, TPP_PAUSE, TPP_IFG
  } tpp_state_e;
  // one client byte
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } tpp_beat_s;
  // one byte toward the physical layer
  typedef struct packed {
    logic       valid;
    logic       pre;
    logic       last;
    logic [7:0] data;
  } tpp_tx_s;
endpackage
`default_nettype wire

// File: rtl/tpp_crc32.sv
// one byte step of the ethernet crc
`timescale 1ns/1ps
`default_nettype none
`include "tpp_consts.svh"
module tpp_crc32 (
  input  wire logic [31:0] crc_in,
  input  wire logic [7:0]  data,
  output logic      [31:0] crc_out
);
  import tpp_pkg::*;
  // reflected polynomial, lsb first
  always_comb begin
    logic [31:0] c;
    c = crc_in ^ {24'h000000, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ `TPP_CRC_POLY) : (c >> 1);
    end
    crc_out = c;
  end
endmodule
`default_nettype wire

// File: rtl/tpp_pause_gen.sv
// byte of a pause frame by position
`timescale 1ns/1ps
`default_nettype none
`include "tpp_consts.svh"
module tpp_pause_gen (
  input  wire logic [5:0]  idx,
  input  wire logic [47:0] src_addr,
  input  wire logic [15:0] quanta,
  input  wire logic [31:0] crc,
  output logic      [7:0]  data
);
  import tpp_pkg::*;
  // byte i of a 48-bit field, sent msb first
  function automatic logic [7:0] sel48(input logic [47:0] v, input logic [5:0] i);
    sel48 = v[8*(5-i) +: 8];
  endfunction
  // da, sa, type, opcode, quanta, pad, fcs
  always_comb begin
    logic [31:0] fcs;
    fcs = ~crc;
    if (idx < 6'd6) data = sel48(`TPP_PAUSE_DA, idx);
    else if (idx < 6'd12) data = sel48(src_addr, idx - 6'd6);
    else if (idx == 6'd12) data = 8'(`TPP_CTL_TYPE >> 8);
    else if (idx == 6'd13) data = 8'(`TPP_CTL_TYPE & 16'h00ff);
    else if (idx == 6'd14) data = 8'(`TPP_PAUSE_OPCODE >> 8);
    else if (idx == 6'd15) data = 8'(`TPP_PAUSE_OPCODE & 16'h00ff);
    else if (idx == 6'd16) data = quanta[15:8];
    else if (idx == 6'd17) data = quanta[7:0];
    else if (idx < `TPP_FCS_START) data = 8'h00;
    else data = fcs[8*(idx-`TPP_FCS_START) +: 8];
  end
endmodule
`default_nettype wire

// File: bench/tpp_phy_sink.sv
// physical layer model that records the first 128 bytes the block transmits
`timescale 1ns/1ps
`default_nettype none
module tpp_phy_sink (
  input wire logic            clk,
  input wire tpp_pkg::tpp_tx_s tx_out
);
  import tpp_pkg::*;
  logic [9:0] got [0:127];  // pre, last, data
  int         n;

  initial n = 0;

  ////////////////////////////////////////////////////////////////////////
  // no back-pressure on the line side: every valid byte is taken
  always @(posedge clk) begin
    if (tx_out.valid === 1'b1 && n < 128) begin
      got[n] <= {tx_out.pre, tx_out.last, tx_out.data};
      n <= n + 1;
    end
  end

  // forget the last frame, only called while the line is quiet
  task automatic clear();
    n = 0;
  endtask
endmodule
`default_nettype wire

// File: bench/test_tpp_top.sv
// self-checking bench of the transmit preamble and pause control block
`timescale 1ns/1ps
`default_nettype none
`include "tpp_consts.svh"
module test_tpp_top;
  import tpp_pkg::*;
  localparam logic [47:0] DA  = 48'h0180c2000001;
  localparam logic [47:0] SRC = 48'h0a1b2c3d4e5f;
  logic        clk;
  logic        sys_rst;
  logic        hsel;
  logic [15:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        cl_valid;
  tpp_beat_s   cl_beat;
  logic        cl_ready;
  tpp_tx_s     tx_out;
  int          n_mismatch;
  int          comparisons;
  int          cycles = 0;
  logic [31:0] rd;
  logic [7:0]  exp_b [0:71];

  tpp_top i_tpp_top (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cl_valid(cl_valid),
    .cl_beat(cl_beat), .cl_ready(cl_ready), .tx_out(tx_out)
  );
  tpp_phy_sink i_tpp_phy_sink (.clk(clk), .tx_out(tx_out));

  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      n_mismatch++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // comparison and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one ahb-lite single word transfer, waits for hready in both phases
  task automatic xfer(input logic w, input logic [13:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [13:0] idx, input logic [31:0] exp, input logic [31:0] m);
    xfer(1'b0, idx, 32'h0);
    check(rd & m, exp);
    check(hresp, 1'b0);
    check(hreadyout, 1'b1);
  endtask

  // client bytes base, base+1, ... with last on the final one
  task automatic send(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      cl_valid <= 1'b1;
      cl_beat <= '{data: 8'(base + i), last: (i == n - 1)};
      @(posedge clk);
      while (cl_ready !== 1'b1) @(posedge clk);
    end
    cl_valid <= 1'b0;
  endtask
  // bounded wait for n bytes, then room for the gap
  task automatic wait_done(input int n_exp);
    int k;
    k = 0;
    while (i_tpp_phy_sink.n < n_exp && k < 300) begin
      @(posedge clk);
      k++;
    end
    repeat (16) @(posedge clk);
  endtask

  // client frame, own preamble or passed through
  task automatic chk_client(input int n, input logic [7:0] base, input logic pass);
    int         t;
    logic [7:0] e;
    t = pass ? n : n + 8;
    check(i_tpp_phy_sink.n, t);
    for (int i = 0; i < t; i++) begin
      if (pass || i > 7)
        e = 8'(base + (pass ? i : i - 8));
      else
        e = (i == 7) ? 8'hd5 : 8'h55;
      check(i_tpp_phy_sink.got[i], {i < 8, i == t - 1, e});
    end
  endtask

  // whole pause frame with preamble, fields and fcs
  task automatic chk_pause(input logic [15:0] q);
    logic [31:0] c;
    for (int i = 0; i < 72; i++) exp_b[i] = (i < 7) ? 8'h55 : 8'h00;
    exp_b[7] = 8'hd5;
    for (int i = 0; i < 6; i++) begin
      exp_b[8 + i] = DA[47 - 8 * i -: 8];
      exp_b[14 + i] = SRC[47 - 8 * i -: 8];
    end
    exp_b[20] = 8'h88;
    exp_b[21] = 8'h08;
    exp_b[23] = 8'h01;
    exp_b[24] = q[15:8];
    exp_b[25] = q[7:0];
    c = 32'hffffffff;
    for (int i = 8; i < 68; i++) begin
      c = c ^ {24'h0, exp_b[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
    end
    c = ~c;
    for (int i = 0; i < 4; i++) exp_b[68 + i] = c[8 * i +: 8];
    check(i_tpp_phy_sink.n, 72);
    for (int i = 0; i < 72; i++)
      check(i_tpp_phy_sink.got[i], {i < 8, i == 71, exp_b[i]});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    n_mismatch = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 16'h0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    cl_valid = 1'b0;
    cl_beat = '0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    // reset values and an unmapped word
    rchk(`TPP_IDX_PRE_CTL, 32'h0, 32'h1);
    rchk(`TPP_IDX_PAUSE_REQ, 32'h0, 32'h3);
    rchk(`TPP_IDX_QUANTA, 32'h0, 32'hffff);
    rchk(`TPP_IDX_PAUSE_EN, 32'h1, 32'h1);
    rchk(14'h1101, 32'h0, 32'hffffffff);
    // own preamble, then passthrough
    send(10, 8'h10);
    wait_done(18);
    chk_client(10, 8'h10, 1'b0);
    i_tpp_phy_sink.clear();
    xfer(1'b1, `TPP_IDX_PRE_CTL, 32'h1);
    rchk(`TPP_IDX_PRE_CTL, 32'h1, 32'h1);
    send(12, 8'h40);
    wait_done(12);
    chk_client(12, 8'h40, 1'b1);
    xfer(1'b1, `TPP_IDX_PRE_CTL, 32'h0);
    // xoff with programmed quanta
    xfer(1'b1, `TPP_IDX_SRC_LO, SRC[31:0]);
    xfer(1'b1, `TPP_IDX_SRC_HI, {16'h0, SRC[47:32]});
    xfer(1'b1, `TPP_IDX_QUANTA, 32'habcd1234);
    rchk(`TPP_IDX_QUANTA, 32'h1234, 32'hffff);
    i_tpp_phy_sink.clear();
    xfer(1'b1, `TPP_IDX_PAUSE_REQ, 32'h2);
    wait_done(72);
    chk_pause(16'h1234);
    rchk(`TPP_IDX_PAUSE_REQ, 32'h0, 32'h3);
    // xon with reserved bits set
    i_tpp_phy_sink.clear();
    xfer(1'b1, `TPP_IDX_PAUSE_REQ, 32'hfffffffd);
    wait_done(72);
    chk_pause(16'h0000);
    // both requests: nothing sent
    i_tpp_phy_sink.clear();
    xfer(1'b1, `TPP_IDX_PAUSE_REQ, 32'h3);
    wait_done(72);
    check(i_tpp_phy_sink.n, 0);
    rchk(`TPP_IDX_PAUSE_REQ, 32'h3, 32'h3);
    xfer(1'b1, `TPP_IDX_PAUSE_REQ, 32'h0);
    // generator disabled, then enabled again
    xfer(1'b1, `TPP_IDX_PAUSE_EN, 32'h0);
    xfer(1'b1, `TPP_IDX_PAUSE_REQ, 32'h2);
    wait_done(72);
    check(i_tpp_phy_sink.n, 0);
    xfer(1'b1, `TPP_IDX_PAUSE_EN, 32'h1);
    wait_done(72);
    chk_pause(16'h1234);
    // three frames started, none while both set or disabled
    rchk(`TPP_IDX_PAUSE_CNT, 32'h3, 32'hffffffff);
    rchk(`TPP_IDX_STATUS, 32'h0, 32'h1);
    complete_run();
  end
endmodule
`default_nettype wire
